// [verilog/sdim_pkg.sv]
// Shared constants for the input mode and timing select block
package sdim_pkg;
  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [3:0] SDIM_CTRL_OFS = 4'h0;
  localparam logic [3:0] SDIM_STAT_OFS = 4'h4;
  localparam logic [3:0] SDIM_LINE_OFS = 4'h8;
  localparam logic [3:0] SDIM_FRAME_OFS = 4'hc;
  // ---------------------------------------------------------------
  // Control fields
  // ---------------------------------------------------------------
  localparam int SDIM_CTRL_WIDTH_BIT = 0;
  localparam int SDIM_CTRL_ASI_BIT = 1;
  localparam int SDIM_CTRL_BYPASS_N_BIT = 2;
  localparam int SDIM_CTRL_EMBED_BIT = 3;
  localparam int SDIM_CTRL_SYNCDE_BIT = 4;
  localparam logic [4:0] SDIM_CTRL_RESET = 5'h05;
  // ---------------------------------------------------------------
  // Status fields
  // ---------------------------------------------------------------
  localparam int SDIM_STAT_MODE_LSB = 0;
  localparam int SDIM_STAT_TSRC_LSB = 2;
  localparam int SDIM_STAT_LOCK_BIT = 4;
  localparam int SDIM_STAT_H_BIT = 5;
  localparam int SDIM_STAT_V_BIT = 6;
  localparam int SDIM_STAT_F_BIT = 7;
  // ---------------------------------------------------------------
  // Timing reference words
  // ---------------------------------------------------------------
  localparam logic [9:0] SDIM_TRS_ONES = 10'h3ff;
  localparam logic [9:0] SDIM_TRS_ZERO = 10'h000;
  localparam int SDIM_XYZ_F_BIT = 8;
  localparam int SDIM_XYZ_V_BIT = 7;
  localparam int SDIM_XYZ_H_BIT = 6;
  // ---------------------------------------------------------------
  // Bus answers
  // ---------------------------------------------------------------
  localparam logic [1:0] SDIM_RESP_OKAY = 2'h0;
  localparam logic [1:0] SDIM_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {SDIM_MODE_SMPTE, SDIM_MODE_ASI, SDIM_MODE_THROUGH} sdim_mode_e;
  typedef enum logic [1:0] {SDIM_TSRC_HVF, SDIM_TSRC_SYNCDE, SDIM_TSRC_EMBED} sdim_tsrc_e;
endpackage

// [verilog/sdim_trs_detect.sv]
// Finds embedded timing reference words and extracts H, V and F
`timescale 1ns/1ps
`default_nettype none
module sdim_trs_detect
  import sdim_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic word_valid,
  input wire logic [9:0] word,
  output logic trs_h,
  output logic trs_v,
  output logic trs_f,
  output logic trs_locked
);
  logic [1:0] zero_run;
  logic seen_ones;

  // ---------------------------------------------------------------
  // Preamble tracking: all-ones then two all-zero words
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seen_ones <= 1'b0;
      zero_run <= 2'h0;
    end else if (word_valid) begin
      if (word == SDIM_TRS_ONES) begin
        seen_ones <= 1'b1;
        zero_run <= 2'h0;
      end else if (seen_ones && word == SDIM_TRS_ZERO && zero_run != 2'h2) begin
        zero_run <= zero_run + 2'h1;
      end else begin
        seen_ones <= 1'b0;
        zero_run <= 2'h0;
      end
    end
  end

  // Flags hold between reference words, so timing is defined between them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trs_h <= 1'b0;
      trs_v <= 1'b0;
      trs_f <= 1'b0;
      trs_locked <= 1'b0;
    end else if (word_valid && seen_ones && zero_run == 2'h2) begin
      trs_h <= word[SDIM_XYZ_H_BIT];
      trs_v <= word[SDIM_XYZ_V_BIT];
      trs_f <= word[SDIM_XYZ_F_BIT];
      trs_locked <= 1'b1;
    end
  end
endmodule // sdim_trs_detect
`default_nettype wire

// [verilog/sdim_timing_mux.sv]
// Chooses the internal timing source and registers H, V and F
`timescale 1ns/1ps
`default_nettype none
module sdim_timing_mux
  import sdim_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic embedded_timing_select,
  input wire logic sync_de_timing_select,
  input wire logic ext_h,
  input wire logic ext_v,
  input wire logic ext_f,
  input wire logic ext_hsync,
  input wire logic ext_vsync,
  input wire logic ext_de,
  input wire logic trs_h,
  input wire logic trs_v,
  input wire logic trs_f,
  output var sdim_tsrc_e tsrc,
  output logic int_h,
  output logic int_v,
  output logic int_f
);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tsrc <= SDIM_TSRC_HVF;
      int_h <= 1'b0;
      int_v <= 1'b0;
      int_f <= 1'b0;
    end else if (embedded_timing_select) begin
      // External timing inputs are not looked at here
      tsrc <= SDIM_TSRC_EMBED;
      int_h <= trs_h;
      int_v <= trs_v;
      int_f <= trs_f;
    end else if (sync_de_timing_select) begin
      // Blanking is the absence of data enable; sync carries no field
      tsrc <= SDIM_TSRC_SYNCDE;
      int_h <= ~ext_de;
      int_v <= ext_vsync & ~ext_de;
      int_f <= 1'b0;
    end else begin
      tsrc <= SDIM_TSRC_HVF;
      int_h <= ext_h;
      int_v <= ext_v;
      int_f <= ext_f;
    end
  end

  // Hsync only qualifies nothing further today; kept for line framing
  logic unused_hsync;
  always_comb begin
    unused_hsync = ext_hsync;
  end
endmodule // sdim_timing_mux
`default_nettype wire

// [verilog/sdim_input_select.sv]
// Input bus width, operating mode and timing source selection
//
// Added by the designer: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module sdim_input_select
  import sdim_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Parallel video from the source, on aclk
  input wire logic word_valid,
  input wire logic [9:0] pri_word,
  input wire logic [9:0] sec_word,
  input wire logic ext_h,
  input wire logic ext_v,
  input wire logic ext_f,
  input wire logic ext_hsync,
  input wire logic ext_vsync,
  input wire logic ext_de,
  // Towards the serializer
  output logic ser_valid,
  output logic [9:0] ser_word_a,
  output logic [9:0] ser_word_b,
  output logic ser_dual,
  output logic scramble_enable,
  output logic ioproc_enable,
  output logic asi_encode_enable,
  output logic asi_k_char,
  output logic int_h,
  output logic int_v,
  output logic int_f
);
  // ---------------------------------------------------------------
  // Control register and derived mode
  // ---------------------------------------------------------------
  logic [4:0] ctrl;
  logic bus_width_select;
  logic async_serial_iface_select;
  logic video_processing_bypass_n;
  logic embedded_timing_select;
  logic sync_de_timing_select;
  sdim_mode_e next_mode;
  sdim_mode_e mode;
  sdim_tsrc_e tsrc;
  logic trs_h;
  logic trs_v;
  logic trs_f;
  logic trs_locked;
  logic prev_h;
  logic prev_v;
  logic [15:0] line_count;
  logic [15:0] frame_count;

  assign bus_width_select = ctrl[SDIM_CTRL_WIDTH_BIT];
  assign async_serial_iface_select = ctrl[SDIM_CTRL_ASI_BIT];
  assign video_processing_bypass_n = ctrl[SDIM_CTRL_BYPASS_N_BIT];
  assign embedded_timing_select = ctrl[SDIM_CTRL_EMBED_BIT];
  assign sync_de_timing_select = ctrl[SDIM_CTRL_SYNCDE_BIT];

  // Processing enable wins over ASI select: processing on means SMPTE whatever ASI says
  always_comb begin
    if (video_processing_bypass_n) begin
      next_mode = SDIM_MODE_SMPTE;
    end else if (async_serial_iface_select) begin
      next_mode = SDIM_MODE_ASI;
    end else begin
      next_mode = SDIM_MODE_THROUGH;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode <= SDIM_MODE_SMPTE;
    end else begin
      mode <= next_mode;
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite write path
  // ---------------------------------------------------------------
  logic aw_held;
  logic w_held;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;

  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 4'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  // Ready is a register so no path runs from valid to ready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= SDIM_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (aw_addr[3:2] == SDIM_CTRL_OFS[3:2]) ? SDIM_RESP_OKAY : SDIM_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Only the low byte lane carries control bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= SDIM_CTRL_RESET;
    end else if (do_write && aw_addr[3:2] == SDIM_CTRL_OFS[3:2] && w_strb[0]) begin
      ctrl <= w_data[4:0];
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite read path
  // ---------------------------------------------------------------
  logic [31:0] next_rdata;
  logic next_rerr;

  always_comb begin
    next_rdata = 32'h0;
    next_rerr = 1'b0;
    case (s_axi_araddr[3:2])
      SDIM_CTRL_OFS[3:2]: next_rdata[4:0] = ctrl;
      SDIM_STAT_OFS[3:2]: begin
        next_rdata[SDIM_STAT_MODE_LSB +: 2] = mode;
        next_rdata[SDIM_STAT_TSRC_LSB +: 2] = tsrc;
        next_rdata[SDIM_STAT_LOCK_BIT] = trs_locked;
        next_rdata[SDIM_STAT_H_BIT] = int_h;
        next_rdata[SDIM_STAT_V_BIT] = int_v;
        next_rdata[SDIM_STAT_F_BIT] = int_f;
      end
      SDIM_LINE_OFS[3:2]: next_rdata[15:0] = line_count;
      SDIM_FRAME_OFS[3:2]: next_rdata[15:0] = frame_count;
      default: next_rerr = 1'b1;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= SDIM_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rerr ? SDIM_RESP_SLVERR : SDIM_RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Timing source selection
  // ---------------------------------------------------------------
  // Reference words ride on the primary word in both bus widths
  sdim_trs_detect u_trs (
    .aclk(aclk),
    .aresetn(aresetn),
    .word_valid(word_valid),
    .word(pri_word),
    .trs_h(trs_h),
    .trs_v(trs_v),
    .trs_f(trs_f),
    .trs_locked(trs_locked)
  );

  sdim_timing_mux u_tmux (
    .aclk(aclk),
    .aresetn(aresetn),
    .embedded_timing_select(embedded_timing_select),
    .sync_de_timing_select(sync_de_timing_select),
    .ext_h(ext_h),
    .ext_v(ext_v),
    .ext_f(ext_f),
    .ext_hsync(ext_hsync),
    .ext_vsync(ext_vsync),
    .ext_de(ext_de),
    .trs_h(trs_h),
    .trs_v(trs_v),
    .trs_f(trs_f),
    .tsrc(tsrc),
    .int_h(int_h),
    .int_v(int_v),
    .int_f(int_f)
  );

  // Line and frame counters make the chosen timing visible to software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_h <= 1'b0;
      prev_v <= 1'b0;
      line_count <= 16'h0;
      frame_count <= 16'h0;
    end else begin
      prev_h <= int_h;
      prev_v <= int_v;
      if (int_h && !prev_h) begin
        line_count <= line_count + 16'h1;
      end
      if (!int_v && prev_v && !int_f) begin
        frame_count <= frame_count + 16'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Data path towards the serializer
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ser_valid <= 1'b0;
      ser_word_a <= 10'h0;
      ser_word_b <= 10'h0;
      ser_dual <= 1'b0;
      asi_k_char <= 1'b0;
    end else begin
      ser_valid <= word_valid;
      ser_word_a <= pri_word;
      asi_k_char <= (next_mode == SDIM_MODE_ASI) && pri_word[8];
      if (bus_width_select && next_mode == SDIM_MODE_SMPTE) begin
        ser_word_b <= sec_word;
        ser_dual <= 1'b1;
      end else if (bus_width_select && next_mode == SDIM_MODE_THROUGH) begin
        ser_word_b <= sec_word;
        ser_dual <= 1'b1;
      end else begin
        ser_word_b <= 10'h0;
        ser_dual <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scramble_enable <= 1'b1;
      ioproc_enable <= 1'b1;
      asi_encode_enable <= 1'b0;
    end else begin
      scramble_enable <= next_mode == SDIM_MODE_SMPTE;
      ioproc_enable <= next_mode != SDIM_MODE_THROUGH;
      asi_encode_enable <= next_mode == SDIM_MODE_ASI;
    end
  end
endmodule // sdim_input_select
`default_nettype wire

// [sim/sdim_input_select_asserts.sv]
// Port-level checker for the input mode and timing select block
`timescale 1ns/1ps
`default_nettype none
module sdim_input_select_asserts
  import sdim_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [9:0] pri_word,
  input wire logic [9:0] sec_word,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [9:0] ser_word_b,
  input wire logic ser_dual,
  input wire logic scramble_enable,
  input wire logic ioproc_enable,
  input wire logic asi_encode_enable,
  input wire logic asi_k_char
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // -------------------------------------------------------------
  // Mode exclusivity and data routing
  // -------------------------------------------------------------
  a_scr_has_io: assert property (scramble_enable |-> ioproc_enable)
    else $error("scramble without io processing");
  a_asi_excl: assert property (asi_encode_enable |-> !scramble_enable && !ser_dual)
    else $error("asi mode overlaps smpte or dual data");
  a_through_off: assert property (!ioproc_enable |-> !scramble_enable && !asi_encode_enable)
    else $error("processing active in data-through");
  a_sec_unused: assert property (!ser_dual |-> ser_word_b == 10'h000)
    else $error("secondary word leaks while unused");
  a_sec_pass: assert property (ser_dual |-> ser_word_b == $past(sec_word))
    else $error("secondary word not passed on");
  a_k_char_src: assert property (asi_k_char |-> $past(pri_word[8]))
    else $error("control character flag without source bit");
  // Bus answers
  a_rd_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_r_taken: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer not retired");
  a_b_taken: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer not retired");
  c_asi: cover property (asi_encode_enable);
  c_smpte_dual: cover property (ser_dual && scramble_enable);
  c_through_dual: cover property (ser_dual && !ioproc_enable);
endmodule // sdim_input_select_asserts
bind sdim_input_select sdim_input_select_asserts sdim_input_select_asserts_i (
  .aclk, .aresetn, .pri_word, .sec_word, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid, .s_axi_bready, .ser_word_b,
  .ser_dual, .scramble_enable, .ioproc_enable, .asi_encode_enable, .asi_k_char
);
`default_nettype wire

// [sim/sdim_src_model.sv]
// Upstream video source: random words, timing lines and reference words
`timescale 1ns/1ps
`default_nettype none
module sdim_src_model
  import sdim_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic trs_go,
  input wire logic [9:0] trs_xyz,
  output logic word_valid,
  output logic [9:0] pri_word,
  output logic [9:0] sec_word,
  output logic ext_h,
  output logic ext_v,
  output logic ext_f,
  output logic ext_hsync,
  output logic ext_vsync,
  output logic ext_de
);
  logic [1:0] trs_cnt;
  initial begin
    {trs_cnt, word_valid, pri_word, sec_word} = '0;
    {ext_h, ext_v, ext_f, ext_hsync, ext_vsync, ext_de} = '0;
  end
  // -------------------------------------------------------------
  // Word stream
  // -------------------------------------------------------------
  always @(posedge aclk) begin
    // Fresh data every cycle, so an ignored word cannot look stable
    sec_word <= 10'($urandom);
    {ext_h, ext_v, ext_f, ext_hsync, ext_vsync, ext_de} <= 6'($urandom);
    if (!aresetn) begin
      trs_cnt <= 2'h0;
      word_valid <= 1'b0;
    end else begin
      trs_cnt <= (trs_cnt != 2'h0 || trs_go) ? trs_cnt + 2'h1 : 2'h0;
      word_valid <= trs_cnt != 2'h0 || trs_go || 1'($urandom);
      case (trs_cnt)
        2'h0: pri_word <= trs_go ? SDIM_TRS_ONES : 10'($urandom);
        2'h3: pri_word <= trs_xyz;
        default: pri_word <= SDIM_TRS_ZERO;
      endcase
    end
  end
endmodule // sdim_src_model
`default_nettype wire

// [sim/sdim_input_select_test.sv]
// Self-checking bench for the input mode and timing select block
`timescale 1ns/1ps
`default_nettype none
module sdim_input_select_test
  import sdim_pkg::*;
;
  logic aclk, aresetn, trs_go;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic word_valid, ext_h, ext_v, ext_f, ext_hsync, ext_vsync, ext_de;
  logic [9:0] pri_word, sec_word, trs_xyz, ser_word_a, ser_word_b, p, s;
  logic ser_valid, ser_dual, scramble_enable, ioproc_enable, asi_encode_enable;
  logic asi_k_char, int_h, int_v, int_f, h, v, f, vs, de, wv;
  int mismatches, cmp_count, m, t, dual, lk;
  int exp_q[$];

  sdim_input_select sdim_input_select_i (.*);
  sdim_src_model sdim_src_model_i (.*);

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  // -------------------------------------------------------------
  // Bus and compare tasks
  // -------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task axi_write(input logic [3:0] a, input logic [31:0] wd, output logic [1:0] br);
    logic aw_ok, w_ok;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= wd;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    do begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end while (s_axi_bvalid !== 1'b1);
    br = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task axi_read(input logic [3:0] a, output logic [31:0] rd);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    s_axi_rready <= 1'b0;
  endtask
  task complete_run;
    $display("Mismatches %0d, comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // -------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------
  initial begin
    {aresetn, trs_go, trs_xyz, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awprot, s_axi_arprot, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    mismatches = 0;
    cmp_count = 0;
    lk = 0;
    void'($urandom(61));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1;
    chk({scramble_enable, ioproc_enable, asi_encode_enable}, 3'h6);
    axi_read(SDIM_CTRL_OFS, d);
    chk(d, SDIM_CTRL_RESET);
    // Read-only places refuse writes and leave control alone
    for (int a = 4; a < 16; a += 4) begin
      axi_write(4'(a), 32'h0000001f, r);
      chk(r, SDIM_RESP_SLVERR);
    end
    axi_read(SDIM_CTRL_OFS, d);
    chk(d, SDIM_CTRL_RESET);
    for (int c = 0; c < 32; c++) begin
      m = c[2] ? 0 : (c[1] ? 1 : 2);
      t = c[3] ? 2 : (c[4] ? 1 : 0);
      dual = c[0] && m != 1;
      axi_write(SDIM_CTRL_OFS, c, r);
      chk(r, SDIM_RESP_OKAY);
      axi_read(SDIM_CTRL_OFS, d);
      chk(d, c);
      axi_read(SDIM_STAT_OFS, d);
      chk(d[3:0], t * 4 + m);
      chk(d[4], lk);
      if (t == 2) chk(d[7:5], trs_xyz[8:6]);
      @(posedge aclk);
      #1;
      chk({scramble_enable, ioproc_enable, asi_encode_enable, ser_dual},
        {m == 0, m != 2, m == 1, dual != 0});
      repeat (8) begin
        @(posedge aclk);
        {p, s, h, v, f, vs, de, wv} =
          {pri_word, sec_word, ext_h, ext_v, ext_f, ext_vsync, ext_de, word_valid};
        exp_q.push_back(dual ? s : 0);
        #1;
        chk(ser_word_a, p);
        chk(ser_valid, wv);
        chk(ser_word_b, exp_q.pop_front());
        chk(asi_k_char, m == 1 && p[8]);
        if (t != 2) chk({int_h, int_v, int_f}, t ? {~de, vs & ~de, 1'b0} : {h, v, f});
      end
      if (t == 2) begin
        @(posedge aclk);
        trs_xyz <= {1'b1, 3'($urandom), 6'h00};
        trs_go <= 1'b1;
        @(posedge aclk);
        trs_go <= 1'b0;
        repeat (8) @(posedge aclk);
        #1;
        chk({int_f, int_v, int_h}, trs_xyz[8:6]);
        lk = 1;
      end
    end
    complete_run();
  end
  initial begin
    #500000;
    mismatches++;
    complete_run();
  end
endmodule // sdim_input_select_test
`default_nettype wire
